/* File: src/epc_ctrl.sv */
// EPROM programmer and reader controller driving the device pins
`timescale 1ns/1ps
module epc_ctrl
  import epc_pkg::*;
#(
  parameter int FAST_PW = EPC_FAST_PW_CYC,
  parameter int INTER_PW = EPC_INTER_PW_CYC,
  parameter int OVER_PW = EPC_OVER_PW_CYC,
  parameter int MAX_PULSES = EPC_FAST_MAX
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_fast,
  input wire logic [EPC_ADDR_W-1:0] cmd_addr,
  input wire logic [EPC_ADDR_W-1:0] cmd_last,
  input wire logic [EPC_DATA_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [EPC_DATA_W-1:0] rsp_data,
  output logic rsp_error,
  output logic rsp_parity_ok,
  output logic [EPC_ADDR_W-1:0] address_lines,
  input wire logic [EPC_DATA_W-1:0] data_lines_in,
  output logic [EPC_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic program_voltage_en,
  output logic identify_high_voltage
);
  epc_state_t state_reg, state_next;
  logic [1:0] op_reg, op_next;
  logic fast_reg, fast_next;
  logic [EPC_ADDR_W-1:0] addr_reg, addr_next, last_reg, last_next;
  logic [EPC_DATA_W-1:0] data_reg, data_next, dout_reg, dout_next;
  logic [5:0] pulses_reg, pulses_next;
  logic ready_reg, ready_next, rv_reg, rv_next, err_reg, err_next, par_reg, par_next;
  logic oe_reg, oe_next, cs_reg, cs_next, og_reg, og_next, vpp_reg, vpp_next, vh_reg, vh_next;
  logic tload;
  logic [EPC_CNT_W-1:0] tcount;
  logic texp;

  // Odd parity across a byte
  function automatic logic odd_parity(input logic [EPC_DATA_W-1:0] b);
    return ^b;
  endfunction

  // Identify address: only the lowest line may be high
  function automatic logic [EPC_ADDR_W-1:0] ident_addr(input logic low);
    return {{(EPC_ADDR_W-1){1'b0}}, low};
  endfunction

  epc_timer #(.W(EPC_CNT_W)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(tload),
    .count(tcount),
    .expired(texp)
  );

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    fast_next = fast_reg;
    addr_next = addr_reg;
    last_next = last_reg;
    data_next = data_reg;
    dout_next = dout_reg;
    pulses_next = pulses_reg;
    ready_next = ready_reg;
    rv_next = 1'b0;
    err_next = err_reg;
    par_next = par_reg;
    oe_next = oe_reg;
    cs_next = cs_reg;
    og_next = og_reg;
    vpp_next = vpp_reg;
    vh_next = vh_reg;
    tload = 1'b0;
    tcount = EPC_CNT_W'(EPC_SETUP_CYC);
    unique case (state_reg)
      EPC_IDLE:
      begin
        if (cmd_valid && ready_reg)
        begin
          ready_next = 1'b0;
          op_next = cmd_op;
          fast_next = cmd_fast;
          addr_next = cmd_addr;
          last_next = cmd_last;
          data_next = cmd_data;
          err_next = 1'b0;
          pulses_next = '0;
          cs_next = 1'b1; // Standby while setting up
          og_next = 1'b1;
          if (cmd_op == EPC_CMD_IDENT)
          begin
            addr_next = ident_addr(cmd_addr[0]);
            vh_next = 1'b1;
          end
          if (cmd_op == EPC_CMD_PROG)
          begin
            vpp_next = 1'b1; // Program supply with select high
            oe_next = 1'b1; // Whole byte in parallel
          end
          tload = 1'b1;
          state_next = EPC_SETUP;
        end
      end
      EPC_SETUP:
      begin
        if (texp)
        begin
          cs_next = 1'b0;
          if (op_reg == EPC_CMD_PROG)
          begin
            if (pulses_reg == 6'h3F)
            begin
              tcount = EPC_CNT_W'(OVER_PW); // Margin pulse after full supply setup
              state_next = EPC_OVER;
            end
            else
            begin
              tcount = fast_reg ? EPC_CNT_W'(FAST_PW) : EPC_CNT_W'(INTER_PW);
              pulses_next = pulses_reg + 6'h01;
              state_next = EPC_PULSE; // Supply high and select low
            end
          end
          else
          begin
            og_next = 1'b0; // Both lows gate data out
            tcount = EPC_CNT_W'(EPC_VERIFY_CYC);
            state_next = EPC_READ;
          end
          tload = 1'b1;
        end
      end
      EPC_PULSE, EPC_OVER:
      begin
        if (texp)
        begin
          cs_next = 1'b1;
          tload = 1'b1;
          state_next = EPC_RECOV;
        end
      end
      EPC_RECOV:
      begin
        if (texp)
        begin
          if (op_reg != EPC_CMD_PROG || (pulses_reg == 6'h3F))
            state_next = EPC_NEXT;
          else
          begin
            vpp_next = 1'b0; // Gate back to logic low for verify
            oe_next = 1'b0;
            og_next = 1'b0;
            cs_next = 1'b0;
            tcount = EPC_CNT_W'(EPC_VERIFY_CYC);
            tload = 1'b1;
            state_next = EPC_VERIFY;
          end
        end
      end
      EPC_VERIFY:
      begin
        if (texp)
        begin
          cs_next = 1'b1; // Sampled after the verify delay
          og_next = 1'b1;
          vpp_next = 1'b1;
          oe_next = 1'b1;
          tload = 1'b1;
          if (data_lines_in == data_reg)
          begin
            if (fast_reg)
            begin
              vpp_next = 1'b0;
              oe_next = 1'b0;
              state_next = EPC_NEXT;
            end
            else
            begin
              pulses_next = 6'h3F; // Extra margin pulse follows
              state_next = EPC_SETUP;
            end
          end
          else if (pulses_reg >= 6'(MAX_PULSES))
          begin
            err_next = 1'b1; // Pulse limit hit
            vpp_next = 1'b0;
            oe_next = 1'b0;
            state_next = EPC_NEXT;
          end
          else
            state_next = EPC_SETUP; // Retry pulse
        end
      end
      EPC_NEXT:
      begin
        vpp_next = 1'b0;
        oe_next = 1'b0;
        pulses_next = '0;
        if (addr_reg == last_reg)
        begin
          addr_next = '0; // Final read-back from address 0 up to the last address
          state_next = EPC_FINAL;
          og_next = 1'b0;
          cs_next = 1'b0;
          tcount = EPC_CNT_W'(EPC_VERIFY_CYC);
          tload = 1'b1;
        end
        else
        begin
          addr_next = addr_reg + EPC_ADDR_W'(1);
          data_next = EPC_ERASED; // Unwritten bytes stay ones
          vpp_next = 1'b1;
          oe_next = 1'b1;
          tload = 1'b1;
          state_next = EPC_SETUP;
          if (cmd_valid)
            data_next = cmd_data;
        end
      end
      EPC_FINAL:
      begin
        if (texp)
        begin
          if (addr_reg == last_reg && data_lines_in != data_reg)
            err_next = 1'b1; // Last byte must read back as written
          if (addr_reg >= last_reg)
          begin
            cs_next = 1'b1;
            og_next = 1'b1;
            state_next = EPC_DONE;
          end
          else
          begin
            addr_next = addr_reg + EPC_ADDR_W'(1);
            tload = 1'b1;
            tcount = EPC_CNT_W'(EPC_VERIFY_CYC);
          end
        end
      end
      EPC_READ:
      begin
        if (texp)
        begin
          dout_next = data_lines_in;
          par_next = odd_parity(data_lines_in);
          cs_next = 1'b1;
          og_next = 1'b1;
          vh_next = 1'b0;
          state_next = EPC_DONE;
        end
      end
      EPC_DONE:
      begin
        rv_next = 1'b1;
        ready_next = 1'b1;
        state_next = EPC_IDLE;
      end
      default:
        state_next = EPC_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= EPC_IDLE;
      op_reg <= EPC_CMD_READ;
      fast_reg <= 1'b0;
      addr_reg <= '0;
      last_reg <= '0;
      data_reg <= EPC_ERASED;
      dout_reg <= '0;
      pulses_reg <= '0;
      ready_reg <= 1'b1;
      rv_reg <= 1'b0;
      err_reg <= 1'b0;
      par_reg <= 1'b0;
      oe_reg <= 1'b0;
      cs_reg <= 1'b1;
      og_reg <= 1'b1;
      vpp_reg <= 1'b0;
      vh_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      fast_reg <= fast_next;
      addr_reg <= addr_next;
      last_reg <= last_next;
      data_reg <= data_next;
      dout_reg <= dout_next;
      pulses_reg <= pulses_next;
      ready_reg <= ready_next;
      rv_reg <= rv_next;
      err_reg <= err_next;
      par_reg <= par_next;
      oe_reg <= oe_next;
      cs_reg <= cs_next;
      og_reg <= og_next;
      vpp_reg <= vpp_next;
      vh_reg <= vh_next;
    end
  end

  // Outputs straight from flops
  assign cmd_ready = ready_reg;
  assign rsp_valid = rv_reg;
  assign rsp_data = dout_reg;
  assign rsp_error = err_reg;
  assign rsp_parity_ok = par_reg;
  assign address_lines = addr_reg;
  assign data_lines_out = data_reg;
  assign data_lines_oe = oe_reg;
  assign chip_select_n = cs_reg;
  assign output_gate_n = og_reg;
  assign program_voltage_en = vpp_reg;
  assign identify_high_voltage = vh_reg;
endmodule

/* File: pkg/epc_pkg.sv */
// Package: constants and types for the EPROM programmer controller
package epc_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int EPC_ADDR_W = 20;
  localparam int EPC_DATA_W = 8;
  localparam int EPC_IDENT_LINE = 9;
  localparam logic [19:0] EPC_LAST_ADDR = 20'hFFFFF;
  localparam logic [7:0] EPC_ERASED = 8'hFF;
  // ----------------------------------------
  // Timing (times in ns, rate 125 MHz)
  // ----------------------------------------
  localparam int EPC_CLK_NS = 8;
  localparam int EPC_SETUP_NS = 2000;
  localparam int EPC_FAST_PW_NS = 100000;
  localparam int EPC_INTER_PW_NS = 1000000;
  localparam int EPC_OVER_PW_NS = 2000000;
  localparam int EPC_VERIFY_NS = 250;
  localparam int EPC_SETUP_CYC = (EPC_SETUP_NS + EPC_CLK_NS - 1) / EPC_CLK_NS;
  localparam int EPC_FAST_PW_CYC = EPC_FAST_PW_NS / EPC_CLK_NS;
  localparam int EPC_INTER_PW_CYC = EPC_INTER_PW_NS / EPC_CLK_NS;
  localparam int EPC_OVER_PW_CYC = EPC_OVER_PW_NS / EPC_CLK_NS;
  localparam int EPC_VERIFY_CYC = (EPC_VERIFY_NS + EPC_CLK_NS - 1) / EPC_CLK_NS;
  localparam int EPC_FAST_MAX = 25;
  localparam int EPC_INTER_MAX = 25;
  localparam int EPC_CNT_W = 20;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [1:0] EPC_CMD_READ = 2'h0;
  localparam logic [1:0] EPC_CMD_IDENT = 2'h1;
  localparam logic [1:0] EPC_CMD_PROG = 2'h2;
  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    EPC_IDLE = 4'h0,
    EPC_SETUP = 4'h1,
    EPC_PULSE = 4'h3,
    EPC_RECOV = 4'h2,
    EPC_VERIFY = 4'h6,
    EPC_OVER = 4'h7,
    EPC_NEXT = 4'h5,
    EPC_FINAL = 4'h4,
    EPC_READ = 4'hC,
    EPC_DONE = 4'hD
  } epc_state_t;
endpackage

/* File: src/epc_timer.sv */
// Down-counting delay timer with a one-cycle expiry pulse
`timescale 1ns/1ps
module epc_timer
  import epc_pkg::*;
#(
  parameter int W = EPC_CNT_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic expired
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic run_reg;
  logic run_next;
  logic expired_reg;
  logic expired_next;

  // Next count, expiry when reaching one
  always_comb
  begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    expired_next = 1'b0;
    if (load)
    begin
      cnt_next = count;
      run_next = 1'b1;
    end
    else if (run_reg)
    begin
      if (cnt_reg <= W'(1))
      begin
        run_next = 1'b0;
        expired_next = 1'b1;
      end
      else
        cnt_next = cnt_reg - W'(1);
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      expired_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;
endmodule

/* File: test/epc_ctrl_chk.sv */
// Checker: pin sequencing assertions for the EPROM controller
`timescale 1ns/1ps
module epc_ctrl_chk
  import epc_pkg::*;
#(
  parameter int FAST_PW = 20,
  parameter int INTER_PW = 20,
  parameter int OVER_PW = 20
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_ready,
  input wire logic [EPC_ADDR_W-1:0] address_lines,
  input wire logic [EPC_DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic program_voltage_en,
  input wire logic identify_high_voltage
);
  // ----------------------------------------
  // Select pulse measurement
  // ----------------------------------------
  int lowc;
  logic pv;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Count select-low cycles, note supply at the fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowc <= 0;
      pv <= 1'b0;
    end
    else
    begin
      lowc <= chip_select_n ? 0 : lowc + 1;
      if ($fell(chip_select_n))
        pv <= program_voltage_en;
    end
  end
  property p_prog_drive;
    program_voltage_en && !chip_select_n |-> data_lines_oe;
  endproperty
  a_prog_drive: assert property (p_prog_drive) else $error("byte not driven in pulse");
  property p_id_addr;
    identify_high_voltage |-> (address_lines & ~20'h00201) == 20'h0;
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("identify with other lines high");
  property p_no_fight;
    !output_gate_n && !program_voltage_en |-> !data_lines_oe;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("driving while device drives");
  property p_hv_excl;
    !(program_voltage_en && identify_high_voltage);
  endproperty
  a_hv_excl: assert property (p_hv_excl) else $error("both high voltages on");
  property p_stable;
    !chip_select_n && program_voltage_en ##1 !chip_select_n |-> $stable(address_lines) && $stable(data_lines_out);
  endproperty
  a_stable: assert property (p_stable) else $error("lines moved while selected");
  property p_pw;
    $rose(chip_select_n) && pv |-> lowc inside {[FAST_PW:FAST_PW+2], [INTER_PW:INTER_PW+2], [OVER_PW:OVER_PW+2]};
  endproperty
  a_pw: assert property (p_pw) else $error("program pulse width wrong");
  property p_vfy;
    $rose(chip_select_n) && !pv |-> lowc >= EPC_VERIFY_CYC;
  endproperty
  a_vfy: assert property (p_vfy) else $error("data taken too early");
  property p_idle;
    cmd_ready |-> chip_select_n && !program_voltage_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle but not standby");
endmodule

bind epc_ctrl epc_ctrl_chk #(.FAST_PW(FAST_PW), .INTER_PW(INTER_PW), .OVER_PW(OVER_PW)) u_chk (.clk, .rst_n,
  .cmd_ready, .address_lines, .data_lines_out, .data_lines_oe, .chip_select_n, .output_gate_n,
  .program_voltage_en, .identify_high_voltage);

/* File: test/epc_dev.sv */
// Behavioural EPROM device on the controller's pins
`timescale 1ns/1ps
module epc_dev
  import epc_pkg::*;
#(
  parameter int NEED = 3,
  parameter logic [7:0] MAN_ID = 8'h23, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h07 // Arbitrary value
)
(
  input wire logic [EPC_ADDR_W-1:0] address_lines,
  output logic [EPC_DATA_W-1:0] data_lines_in,
  input wire logic [EPC_DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic program_voltage_en,
  input wire logic identify_high_voltage
);
  logic [7:0] mem [int];
  logic [7:0] rd = 8'hFF;
  logic [19:0] pa = 20'hFFFFF;
  int hits = 0;
  wire sel = !chip_select_n && !output_gate_n && !program_voltage_en;
  wire #250 sel_d = sel;
  wire idm = identify_high_voltage && (address_lines & ~20'h00201) == 20'h0;
  // Stored byte, erased default, or identity byte
  always @(posedge sel_d or address_lines or idm)
    rd = idm ? (address_lines[0] ? DEV_ID : MAN_ID) : mem.exists(address_lines) ? mem[address_lines] : EPC_ERASED;
  // Inverse byte when nobody drives
  assign data_lines_in = sel && sel_d ? rd : data_lines_oe ? data_lines_out : ~rd;
  // Pulse with supply on: bits only fall, after NEED pulses
  always @(negedge chip_select_n)
  begin
    #1; // Let supply and drive settle after the select edge
    if (program_voltage_en && data_lines_oe && !chip_select_n)
    begin
      if (address_lines != pa)
        hits = 0;
      pa = address_lines;
      hits++;
      if (hits >= NEED)
        mem[address_lines] = (mem.exists(address_lines) ? mem[address_lines] : EPC_ERASED) & data_lines_out;
    end
  end
endmodule

/* File: test/epc_ctrl_tb.sv */
// Testbench: command table and reset case for the EPROM controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module epc_ctrl_tb
  import epc_pkg::*;
;
  localparam logic [7:0] MAN = 8'h23; // Arbitrary value
  localparam logic [7:0] DEV = 8'h07; // Arbitrary value
  typedef struct packed {logic [1:0] op; logic f; logic [19:0] a; logic [19:0] l; logic [7:0] d; logic [7:0] q; logic e;} epc_row_t;
  logic clk = 0, rst_n = 0, cmd_valid = 0, cmd_fast = 0;
  logic [1:0] cmd_op = 2'h0;
  logic [19:0] cmd_addr = 20'h0, cmd_last = 20'h0, address_lines;
  logic [7:0] cmd_data = 8'h00, rsp_data, data_lines_in, data_lines_out;
  logic cmd_ready, rsp_valid, rsp_error, rsp_parity_ok, data_lines_oe;
  logic chip_select_n, output_gate_n, program_voltage_en, identify_high_voltage;
  int n_mismatch = 0, checks_done = 0;
  // Op, fast, start, last, data, expected byte, expected error
  epc_row_t rows [10] = '{
    '{2'h0, 1'b0, 20'h5, 20'h0, 8'h00, 8'hFF, 1'b0},
    '{2'h1, 1'b0, 20'h0, 20'h0, 8'h00, MAN, 1'b0},
    '{2'h1, 1'b0, 20'h1, 20'h0, 8'h00, DEV, 1'b0},
    '{2'h2, 1'b1, 20'h3, 20'h4, 8'hA5, 8'h00, 1'b0},
    '{2'h0, 1'b0, 20'h3, 20'h0, 8'h00, 8'hA5, 1'b0},
    '{2'h0, 1'b0, 20'h4, 20'h0, 8'h00, 8'hFF, 1'b0},
    '{2'h2, 1'b0, 20'hA, 20'hA, 8'h3C, 8'h00, 1'b0},
    '{2'h0, 1'b0, 20'hA, 20'h0, 8'h00, 8'h3C, 1'b0},
    '{2'h2, 1'b1, 20'h3, 20'h3, 8'h5A, 8'h00, 1'b1},
    '{2'h0, 1'b0, 20'h3, 20'h0, 8'h00, 8'h00, 1'b0}};
  // Clock at 125 MHz
  always #4 clk = ~clk;
  epc_ctrl #(.FAST_PW(20), .INTER_PW(40), .OVER_PW(80), .MAX_PULSES(25)) DUT (.clk, .rst_n, .cmd_valid,
    .cmd_op, .cmd_fast, .cmd_addr, .cmd_last, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_error,
    .rsp_parity_ok, .address_lines, .data_lines_in, .data_lines_out, .data_lines_oe, .chip_select_n,
    .output_gate_n, .program_voltage_en, .identify_high_voltage);
  epc_dev #(.NEED(3), .MAN_ID(MAN), .DEV_ID(DEV)) u_dev (.address_lines, .data_lines_in, .data_lines_out,
    .data_lines_oe, .chip_select_n, .output_gate_n, .program_voltage_en, .identify_high_voltage);
  // Counts and verdict, then stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One command, wait for its completion pulse
  task automatic run(input epc_row_t r);
    int i;
    @(negedge clk);
    {cmd_op, cmd_fast, cmd_addr, cmd_last, cmd_data} = {r.op, r.f, r.a, r.l, r.d};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 30000 && rsp_valid !== 1'b1; i++)
      @(negedge clk);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      run(rows[k]);
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_error, rows[k].e)
      if (rows[k].op != EPC_CMD_PROG)
      begin
        `CHK(rsp_data, rows[k].q)
        `CHK(rsp_parity_ok, ^rows[k].q)
      end
      $display("test %0d done", k);
    end
    // Request held while busy, then reset in the pulse
    @(negedge clk);
    {cmd_op, cmd_fast, cmd_addr, cmd_last, cmd_data} = {EPC_CMD_PROG, 1'b1, 20'h20, 20'h20, 8'h0F};
    cmd_valid = 1'b1;
    repeat (260) @(negedge clk);
    cmd_valid = 1'b0;
    rst_n = 1'b0;
    #1;
    `CHK({chip_select_n, program_voltage_en, cmd_ready}, 3'b101)
    @(negedge clk);
    rst_n = 1'b1;
    run('{2'h0, 1'b0, 20'h20, 20'h0, 8'h00, 8'hFF, 1'b0});
    `CHK(rsp_data, 8'hFF)
    $display("test reset done");
    complete_run();
  end
  // Watchdog: about twice the 22000 cycles the table and reset case need
  initial
  begin
    #400000;
    n_mismatch++;
    complete_run();
  end
endmodule
